/* fpc_pkg.sv */
package fpc_pkg;
    // ==================================================================
    // register map (byte addresses on the 32-bit bus)
    localparam logic [31:0] OFS_CTRL       = 32'h0000_0000;
    localparam logic [31:0] OFS_KEY        = 32'h0000_0004;
    localparam logic [31:0] OFS_ADDR       = 32'h0000_0008;
    localparam logic [31:0] OFS_STAT       = 32'h0000_000c;

    // ==================================================================
    // control register fields and reset values
    localparam int          WR_BIT         = 15;
    localparam int          WRITE_ENABLE_BIT_BIT       = 14;
    localparam int          ERR_BIT        = 13;
    localparam int          ARRAY_SELECT_LO      = 3;
    localparam int          SIZE_LO        = 1;
    localparam int          ERASE_BIT      = 0;
    localparam int          DONE_BIT       = 0;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] ADDR_RST       = 16'h0000;
    localparam logic [7:0]  KEY_FIRST      = 8'h55;
    localparam logic [7:0]  KEY_SECOND     = 8'haa;

    // ==================================================================
    // array and unit size encodings
    localparam logic [1:0]  MEM_PROG       = 2'h0;
    localparam logic [1:0]  MEM_DATA       = 2'h1;
    localparam logic [1:0]  MEM_CFG        = 2'h2;
    localparam logic [1:0]  MEM_ALL        = 2'h3;
    localparam logic [1:0]  SIZE_WORD      = 2'h0;
    localparam logic [1:0]  SIZE_MULTI     = 2'h1;
    localparam logic [1:0]  SIZE_RSVD      = 2'h2;
    localparam logic [1:0]  SIZE_ALL       = 2'h3;

    // ==================================================================
    // geometry: a row is 32 words, a latch group 4 words, two address units per word
    localparam int          ROW_WORDS      = 32;
    localparam int          LATCH_WORDS    = 4;
    localparam int          INSTR_W        = 24;
    localparam logic [15:0] ROW_ADDR_MASK  = 16'hffc0;
    localparam logic [15:0] QUAD_ADDR_MASK = 16'hfff8;

    // ==================================================================
    // timing
    localparam int          CYCLE_TIME_NS  = 2000000;
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          CYCLE_COUNT    = CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int          TMR_W          = 20;

    // ==================================================================
    // bus responses and unlock states
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_ARMED
    } fpc_key_st_t;
endpackage : fpc_pkg

/* fpc_tmr_if.sv */
`timescale 1ns/10ps
interface fpc_tmr_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport ctl (output start, output abort, input busy, input done);
    modport tmr (input start, input abort, output busy, output done);
endinterface : fpc_tmr_if

/* fpc_cycle_timer.sv */
`timescale 1ns/10ps
module fpc_cycle_timer #(
    parameter int unsigned CYCLES = fpc_pkg::CYCLE_COUNT
) (
    // clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic ce,
    // control side
    fpc_tmr_if.tmr    tif
);
    import fpc_pkg::*;

    logic [TMR_W-1:0] cnt_q;
    logic             busy_q;
    logic             done_q;

    assign tif.busy = busy_q;
    assign tif.done = done_q;

    // ==================================================================
    // self-timed cycle; abort wins over start and over the last count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (tif.abort) begin
                busy_q <= 1'b0;
            end else if (tif.start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= TMR_W'(CYCLES - 1);
            end else if (busy_q && cnt_q == '0) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else if (busy_q) begin
                cnt_q  <= cnt_q - 1'b1;
            end
        end
    end

    a_timer_load : assert property (@(posedge sys_clk) disable iff (!nrst || !ce)
        (tif.start && !tif.abort && !busy_q) |=> (busy_q && cnt_q == TMR_W'(CYCLES - 1)))
        else $error("timer not loaded with full cycle length");
endmodule : fpc_cycle_timer

/* fpc_flash_ctrl.sv */
// Function
// - erase program flash in 32-word rows, program it in 4-word latch groups
// - keys 0x55 then 0xAA must precede any start; otherwise refused
// - processor stays stalled for the whole program-flash cycle
// - write-start bit clears itself when the cycle ends; zero means done
// - software can set write-start; writing zero does nothing
// - write enable must be one for any erase or program to happen
// - pin or watchdog reset during a cycle sets abort flag; success clears it
// - array select bits 4-3 choose program, data, configuration or all
// - unit size bits 2-1 choose word, multi-word or chip; 10 reserved
// - bit 0 chooses erase when one, program when zero
// - control bits 12-5 read zero; software writes zero
// - key register takes bits 7-0, is write-only, reads zero
// - address register captures each table write address, also software read/write
// - address register picks the location or row a cycle acts on
// - four 24-bit latches filled by low-word and high-byte table writes
// - a cycle lasts 2 msec, timed internally
// - start is refused unless write enable was set by an earlier write
// - wrong key order means the cycle is not started
`timescale 1ns/10ps
module fpc_flash_ctrl #(
    parameter int unsigned CYCLE_CYCLES = fpc_pkg::CYCLE_COUNT
) (
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // axi4-lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // table writes from the core
    input  wire logic        tw_valid,
    input  wire logic        tw_high,
    input  wire logic [15:0] tw_ea,
    input  wire logic [15:0] tw_data,
    // reset sources that abort a cycle
    input  wire logic        external_pin_reset_n,
    input  wire logic        watchdog_reset_source,
    // flash array command
    output logic             fl_start,
    output logic             fl_abort,
    output logic             fl_erase,
    output logic [1:0]       fl_array,
    output logic [1:0]       fl_size,
    output logic [15:0]      fl_addr,
    output logic [95:0]      fl_data,
    // core side
    output logic             cpu_stall,
    output logic             flash_done_irq_flag
);
    import fpc_pkg::*;

    // ==================================================================
    // state
    fpc_tmr_if     tif ();
    fpc_key_st_t   key_st_q, key_st_d;
    logic          awready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]    bresp_q, rresp_q;
    logic [31:0]   rdata_q;
    logic          wr_q, write_enable_bit_q, write_abort_flag_q, erase_q;
    logic [1:0]    array_select_q, unit_size_select_q;
    logic [15:0]   addr_q;
    logic          done_q, stall_q, start_q, abort_q;
    logic          fl_erase_q;
    logic [1:0]    fl_array_q, fl_size_q;
    logic [15:0]   fl_addr_q, fl_addr_d;
    logic [95:0]   fl_data_q, latch_flat;
    logic [INSTR_W-1:0] latch_q [LATCH_WORDS];
    logic [2:0]    pin_sync_q;
    logic          pin_lvl_q;

    // ==================================================================
    // bus decode
    wire        wr_take   = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    wire        wr_fire   = awready_q;
    wire        rd_take   = s_axi_arvalid && !arready_q && !rvalid_q;
    wire        rd_fire   = arready_q;
    wire        hit_ctrl  = wr_fire && s_axi_awaddr == OFS_CTRL;
    wire        hit_key   = wr_fire && s_axi_awaddr == OFS_KEY;
    wire        hit_addr  = wr_fire && s_axi_awaddr == OFS_ADDR;
    wire        hit_stat  = wr_fire && s_axi_awaddr == OFS_STAT;
    wire        w_mapped  = hit_ctrl || hit_key || hit_addr || hit_stat;
    wire [15:0] wmask     = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [15:0] ctrl_rd   = {wr_q, write_enable_bit_q, write_abort_flag_q, 8'h00,
                             array_select_q, unit_size_select_q, erase_q};
    wire [15:0] ctrl_wv   = (ctrl_rd & ~wmask) | (s_axi_wdata[15:0] & wmask);
    wire [15:0] addr_wv   = (addr_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
    wire [7:0]  key_byte  = s_axi_wdata[7:0];
    wire        key_wr    = hit_key && s_axi_wstrb[0];
    wire [1:0]  new_mem   = ctrl_wv[ARRAY_SELECT_LO +: 2];
    wire [1:0]  new_size  = ctrl_wv[SIZE_LO +: 2];
    wire        r_ctrl    = s_axi_araddr == OFS_CTRL;
    wire        r_key     = s_axi_araddr == OFS_KEY;
    wire        r_addr    = s_axi_araddr == OFS_ADDR;
    wire        r_stat    = s_axi_araddr == OFS_STAT;
    wire        r_mapped  = r_ctrl || r_key || r_addr || r_stat;
    // key reads as zero: write-only
    wire [15:0] rd_mux    = r_ctrl ? ctrl_rd :
                            r_addr ? addr_q  :
                            r_stat ? {15'h0000, done_q} : 16'h0000;

    // ==================================================================
    // start, completion and abort conditions
    wire size_ok   = new_size != SIZE_RSVD && !(new_size == SIZE_WORD && new_mem != MEM_DATA);
    wire start_req = hit_ctrl && s_axi_wstrb[1] && s_axi_wdata[WR_BIT] && !wr_q
                     && key_st_q == KEY_ARMED
                     && write_enable_bit_q
                     && size_ok;
    wire abort_ev  = wr_q && (!pin_lvl_q || watchdog_reset_source);
    wire done_ok   = tif.done && !abort_ev;
    wire tw_take   = tw_valid && !stall_q;

    assign tif.start = start_q;
    assign tif.abort = abort_ev;

    fpc_cycle_timer #(
        .CYCLES (CYCLE_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .tif     (tif)
    );

    // ==================================================================
    // unlock sequence: any write other than the next key cancels it
    always_comb begin
        key_st_d = key_st_q;
        if (abort_ev) begin
            key_st_d = KEY_IDLE;
        end else if (wr_fire) begin
            key_st_d = KEY_IDLE;
            if (key_wr && key_byte == KEY_FIRST) begin
                key_st_d = KEY_GOT_FIRST;
            end else if (key_wr && key_byte == KEY_SECOND && key_st_q == KEY_GOT_FIRST) begin
                key_st_d = KEY_ARMED;
            end
        end
    end

    // ==================================================================
    // pin reset synchroniser: a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_sync_q <= 3'h7;
            pin_lvl_q  <= 1'b1;
        end else if (ce) begin
            pin_sync_q <= {pin_sync_q[1:0], external_pin_reset_n};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end

    // ==================================================================
    // axi4-lite handshakes; address and data are taken together
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else if (ce) begin
            awready_q <= wr_take;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else if (ce) begin
            arready_q <= rd_take;
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q  <= {16'h0000, rd_mux};
                rresp_q  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // control register; configuration may change mid-cycle without effect on it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            key_st_q           <= KEY_IDLE;
            write_enable_bit_q <= CTRL_RST[WRITE_ENABLE_BIT_BIT];
            array_select_q     <= CTRL_RST[ARRAY_SELECT_LO +: 2];
            unit_size_select_q <= CTRL_RST[SIZE_LO +: 2];
            erase_q            <= CTRL_RST[ERASE_BIT];
        end else if (ce) begin
            key_st_q <= key_st_d;
            if (hit_ctrl) begin
                write_enable_bit_q <= ctrl_wv[WRITE_ENABLE_BIT_BIT];
                array_select_q     <= new_mem;
                unit_size_select_q <= new_size;
                erase_q            <= ctrl_wv[ERASE_BIT];
            end
        end
    end

    // write-start clears only by hardware; the set from an abort beats a software clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q               <= CTRL_RST[WR_BIT];
            write_abort_flag_q <= CTRL_RST[ERR_BIT];
            done_q             <= 1'b0;
        end else if (ce) begin
            if (abort_ev || tif.done) begin
                wr_q <= 1'b0;
            end else if (start_req) begin
                wr_q <= 1'b1;
            end
            if (abort_ev) begin
                write_abort_flag_q <= 1'b1;
            end else if (tif.done) begin
                write_abort_flag_q <= 1'b0;
            end else if (hit_ctrl) begin
                write_abort_flag_q <= ctrl_wv[ERR_BIT];
            end
            if (done_ok) begin
                done_q <= 1'b1;
            end else if (hit_stat && s_axi_wstrb[0] && s_axi_wdata[DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // address register: table writes win over a software write in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= ADDR_RST;
        end else if (ce) begin
            if (tw_take) begin
                addr_q <= tw_ea;
            end else if (hit_addr) begin
                addr_q <= addr_wv;
            end
        end
    end

    // ==================================================================
    // write latches: low word and high byte per entry, picked by the word address
    generate
        for (genvar i = 0; i < LATCH_WORDS; i++) begin : g_latch
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    latch_q[i] <= '0;
                end else if (ce && tw_take && tw_ea[2:1] == 2'(i)) begin
                    if (tw_high) begin
                        latch_q[i][23:16] <= tw_data[7:0];
                    end else begin
                        latch_q[i][15:0]  <= tw_data;
                    end
                end
            end
            assign latch_flat[i*INSTR_W +: INSTR_W] = latch_q[i];
        end
    endgenerate

    // ==================================================================
    // flash command: multi-word program flash cycles act on a whole row or on a four-word group
    assign fl_addr_d = (new_mem != MEM_PROG || new_size != SIZE_MULTI) ? addr_q :
                       ctrl_wv[ERASE_BIT] ? (addr_q & ROW_ADDR_MASK) :
                                            (addr_q & QUAD_ADDR_MASK);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
            fl_erase_q <= 1'b0;
            fl_array_q <= MEM_PROG;
            fl_size_q  <= SIZE_WORD;
            fl_addr_q  <= ADDR_RST;
            fl_data_q  <= '0;
        end else if (ce) begin
            start_q <= start_req;
            abort_q <= abort_ev;
            if (start_req) begin
                fl_erase_q <= ctrl_wv[ERASE_BIT];
                fl_array_q <= new_mem;
                fl_size_q  <= new_size;
                fl_addr_q  <= fl_addr_d;
                fl_data_q  <= latch_flat;
            end
        end
    end

    // data flash cycles run in the background; everything else holds the core
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stall_q <= 1'b0;
        end else if (ce) begin
            if (abort_ev || tif.done) begin
                stall_q <= 1'b0;
            end else if (start_req) begin
                stall_q <= new_mem != MEM_DATA;
            end
        end
    end

    // ==================================================================
    // outputs
    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = awready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rresp         = rresp_q;
    assign s_axi_rdata         = rdata_q;
    assign fl_start            = start_q;
    assign fl_abort            = abort_q;
    assign fl_erase            = fl_erase_q;
    assign fl_array            = fl_array_q;
    assign fl_size             = fl_size_q;
    assign fl_addr             = fl_addr_q;
    assign fl_data             = fl_data_q;
    assign cpu_stall           = stall_q;
    assign flash_done_irq_flag = done_q;

    // ==================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst || !ce);

    sequence s_unlocked;
        key_st_q == KEY_GOT_FIRST ##1 key_st_q == KEY_ARMED;
    endsequence
    sequence s_cycle_end;
        tif.done && !abort_ev ##1 (!wr_q && !stall_q && done_q && !write_abort_flag_q);
    endsequence

    a_start_keyed : assert property (start_q |-> $past(key_st_q) == KEY_ARMED)
        else $error("cycle started without unlock");
    a_key_order : assert property (s_unlocked |-> $past(key_wr, 1) && $past(key_byte, 1) == KEY_SECOND)
        else $error("unlock armed out of order");
    a_start_write_enable_bit : assert property (start_q |-> $past(write_enable_bit_q))
        else $error("start accepted without earlier write enable");
    a_cycle_end : assert property (done_ok |-> s_cycle_end)
        else $error("write-start not cleared at cycle end");
    a_zero_noeffect : assert property ((wr_q && hit_ctrl && !s_axi_wdata[WR_BIT] && !tif.done && !abort_ev)
        |=> wr_q)
        else $error("software write of zero cleared write-start");
    a_abort_flag : assert property (abort_ev |=> (write_abort_flag_q && !wr_q && !stall_q))
        else $error("reset abort did not set flag");
    a_no_irq_abort : assert property ((abort_ev && !done_q && !hit_stat) |=> !done_q)
        else $error("completion flag set by an abort");
    a_stall_busy : assert property (stall_q |-> wr_q)
        else $error("core stalled with no cycle running");
    a_timer_in_cycle : assert property (tif.busy |-> wr_q)
        else $error("timer running with write-start clear");
    a_rsvd_size : assert property (start_q |-> fl_size_q != SIZE_RSVD)
        else $error("reserved unit size started");
    a_row_align : assert property ((start_q && fl_erase_q && fl_array_q == MEM_PROG && fl_size_q == SIZE_MULTI)
        |-> fl_addr_q[5:0] == 6'h00)
        else $error("row erase address not row aligned");
    a_addr_capture : assert property (tw_take |=> addr_q == $past(tw_ea))
        else $error("table write address not captured");
endmodule : fpc_flash_ctrl

/* fpc_core_model.sv */
`timescale 1ns/10ps
module fpc_core_model (
    // clock and stall
    input  wire logic   sys_clk,
    input  wire logic   cpu_stall,
    // table writes
    output logic        tw_valid,
    output logic        tw_high,
    output logic [15:0] tw_ea,
    output logic [15:0] tw_data
);
    initial begin
        tw_valid = 1'b0;
        tw_high = 1'b0;
        tw_ea = '0;
        tw_data = '0;
    end
    // a stalled core executes nothing, so a table write waits out the stall
    task automatic tblwt(input logic h, input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        while (cpu_stall) @(posedge sys_clk);
        tw_valid <= 1'b1;
        tw_high <= h;
        tw_ea <= a;
        tw_data <= d;
        @(posedge sys_clk);
        tw_valid <= 1'b0;
        tw_ea <= ~a;
        tw_data <= ~d;
    endtask : tblwt
endmodule : fpc_core_model

/* fpc_flash_ctrl_bench.sv */
`timescale 1ns/10ps
module fpc_flash_ctrl_bench;
    import fpc_pkg::*;
    localparam int unsigned CYC = 20;
    logic        sys_clk = 0, nrst = 0, wdog = 0, awv = 0, arv = 0, pin = 1;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic        awrdy, wrdy, bv, arrdy, rv, tv, th, st, ab, er, stall, irq, c_er;
    logic [1:0]  bresp, rresp, ar, sz, c_ar, c_sz;
    logic [15:0] tea, tdat, fa, c_fa;
    logic [95:0] fd, c_fd, x_fd;
    int          error_cnt = 0, check_count = 0, ticks = 0, starts = 0, stalled = 0, aborts = 0;

    fpc_flash_ctrl #(.CYCLE_CYCLES(CYC)) DUT (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(awv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(1'b1), .tw_valid(tv), .tw_high(th), .tw_ea(tea), .tw_data(tdat),
        .external_pin_reset_n(pin), .watchdog_reset_source(wdog), .fl_start(st), .fl_abort(ab),
        .fl_erase(er), .fl_array(ar), .fl_size(sz), .fl_addr(fa), .fl_data(fd),
        .cpu_stall(stall), .flash_done_irq_flag(irq));
    fpc_core_model CORE (.sys_clk(sys_clk), .cpu_stall(stall), .tw_valid(tv), .tw_high(th),
        .tw_ea(tea), .tw_data(tdat));

    always #2.5 sys_clk = ~sys_clk;
    // ==========
    // monitor and hang guard
    always @(posedge sys_clk) begin
        ticks <= ticks + 1;
        stalled <= st ? 0 : stalled + stall;
        aborts <= aborts + ab;
        if (st) begin
            starts <= starts + 1;
            {c_er, c_ar, c_sz, c_fa, c_fd} <= {er, ar, sz, fa, fd};
        end
        if (ticks == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        do @(posedge sys_clk); while (awrdy !== 1'b1 || wrdy !== 1'b1);
        awv <= 1'b0;
        while (bv !== 1'b1) @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        araddr <= a;
        arv <= 1'b1;
        do @(posedge sys_clk); while (arrdy !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge sys_clk);
        chk(rdata, exp);
    endtask : rd
    task automatic go(input logic [15:0] c);
        wr(OFS_KEY, {24'h0, KEY_FIRST});
        wr(OFS_KEY, {24'h0, KEY_SECOND});
        wr(OFS_CTRL, {16'h0, c});
        repeat (2) @(posedge sys_clk);
    endtask : go
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // ==========
    // tests
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(OFS_CTRL, 0);
        wr(OFS_CTRL, 32'h1fe0);
        rd(OFS_CTRL, 0);
        rd(OFS_KEY, 0);
        rd(32'h40, 0);
        chk({30'h0, rresp}, RESP_SLVERR);
        wr(32'h40, 0);
        chk({30'h0, bresp}, RESP_SLVERR);
        CORE.tblwt(1'b0, 16'h6000, 16'h1234);
        rd(OFS_ADDR, 32'h6000);
        wr(OFS_ADDR, 32'h6046);
        rd(OFS_ADDR, 32'h6046);
        $display("regs done");
        go(16'hc003);
        rd(OFS_CTRL, 32'h4003);
        wr(OFS_KEY, 32'haa);
        wr(OFS_KEY, 32'h55);
        wr(OFS_CTRL, 32'hc003);
        wr(OFS_KEY, 32'h55);
        wr(OFS_KEY, 32'haa);
        wr(OFS_ADDR, 32'h6046);
        wr(OFS_CTRL, 32'hc003);
        wr(OFS_CTRL, 32'h4005);
        go(16'hc005);
        rd(OFS_CTRL, 32'h4005);
        wr(OFS_CTRL, 32'h0003);
        go(16'h8003);
        rd(OFS_CTRL, 32'h0003);
        chk(starts, 0);
        $display("refusals done");
        wr(OFS_CTRL, 32'h4003);
        go(16'hc003);
        rd(OFS_CTRL, 32'hc003);
        repeat (CYC + 4) @(posedge sys_clk);
        rd(OFS_CTRL, 32'h4003);
        rd(OFS_STAT, 1);
        chk(irq, 1);
        chk(stalled >= CYC && stalled <= CYC + 2, 1);
        chk({c_er, c_ar, c_sz, c_fa}, {1'b1, MEM_PROG, SIZE_MULTI, 16'h6040});
        wr(OFS_STAT, 1);
        $display("erase done");
        for (int p = 0; p < 8; p++) begin
            for (int i = 0; i < 4; i++) begin
                CORE.tblwt(1'b0, 16'h6040 + 16'(8 * p + 2 * i), 16'h1000 + 16'(16 * p + i));
                CORE.tblwt(1'b1, 16'h6040 + 16'(8 * p + 2 * i), 16'h0020 + 16'(i));
                x_fd[24 * i +: 24] = {8'h20 + 8'(i), 16'h1000 + 16'(16 * p + i)};
            end
            wr(OFS_CTRL, 32'h4002);
            go(16'hc002);
            repeat (CYC + 4) @(posedge sys_clk);
            chk({c_er, c_fa}, {1'b0, 16'h6040 + 16'(8 * p)});
            chk(c_fd == x_fd, 1);
            wr(OFS_STAT, 1);
        end
        go(16'hc002);
        wdog <= 1'b1;
        @(posedge sys_clk);
        wdog <= 1'b0;
        rd(OFS_CTRL, 32'h6002);
        rd(OFS_STAT, 0);
        go(16'hc002);
        pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
        pin <= 1'b1;
        rd(OFS_CTRL, 32'h6002);
        go(16'he002);
        wr(OFS_CTRL, 32'h6002);
        rd(OFS_CTRL, 32'he002);
        repeat (CYC + 4) @(posedge sys_clk);
        rd(OFS_CTRL, 32'h4002);
        chk(starts, 12);
        chk(aborts, 2);
        $display("program done");
        end_sim();
    end
endmodule : fpc_flash_ctrl_bench
